//--- design/fp_regfile_pkg.sv
// Package: floating-point register entry layout, class types and conversion constants
package fp_regfile_pkg;

    // Entry layout: sign, 17-bit biased exponent, 64-bit significand
    localparam int ENTRY_W    = 82;
    localparam int EXP_W      = 17;
    localparam int SIG_W      = 64;
    localparam int SIGN_POS   = 81;
    localparam int EXP_LSB    = 64;
    localparam int INT_BIT    = 63;
    localparam int QUIET_BIT  = 62;

    // Register-format exponent constants
    localparam logic [16:0] EXP_ZERO     = 17'h00000;
    localparam logic [16:0] EXP_SPECIAL  = 17'h1FFFF;
    localparam logic [16:0] EXP_MAX_FIN  = 17'h1FFFE;
    localparam logic [16:0] EXP_REG_BIAS = 17'h0FFFF;
    localparam logic [16:0] EXP_INT      = 17'h1003E;
    localparam int          DENORM_EXP   = -16382;

    // Subset ranges inside the register format
    localparam logic [16:0] SGL_EXP_LO = 17'h0FF81;
    localparam logic [16:0] SGL_EXP_HI = 17'h1007E;
    localparam logic [16:0] DBL_EXP_LO = 17'h0FC01;
    localparam logic [16:0] DBL_EXP_HI = 17'h103FE;
    localparam logic [16:0] EXT_EXP_LO = 17'h0C001;
    localparam logic [16:0] EXT_EXP_HI = 17'h13FFE;
    localparam int          SGL_PAD    = 40;
    localparam int          DBL_PAD    = 11;

    // Memory formats: exponent widths, fraction widths, biases, total widths
    localparam int SGL_EW = 8;
    localparam int DBL_EW = 11;
    localparam int EXT_EW = 15;
    localparam int SGL_FW = 23;
    localparam int DBL_FW = 52;
    localparam int EXT_FW = 64;
    localparam int SGL_BIAS = 127;
    localparam int DBL_BIAS = 1023;
    localparam int EXT_BIAS = 16383;
    localparam int SGL_TOTAL = 32;
    localparam int DBL_TOTAL = 64;
    localparam int EXT_TOTAL = 80;

    // Reset values
    localparam logic [81:0] ENTRY_RESET = 82'h0;

    typedef struct packed {
        logic        sign;
        logic [16:0] exp;
        logic [63:0] sig;
    } entry_t;

    localparam entry_t ENTRY_ZERO = '{sign: 1'b0, exp: 17'h00000, sig: 64'h0};
    localparam entry_t ENTRY_ONE  = '{sign: 1'b0, exp: 17'h0FFFF,
                                      sig: 64'h8000000000000000};
    localparam entry_t ENTRY_TOKEN = '{sign: 1'b0, exp: 17'h1FFFE, sig: 64'h0};

    // One-hot encoding class
    typedef struct packed {
        logic zero;
        logic normal;
        logic unnormal;
        logic inf;
        logic qnan;
        logic snan;
        logic pseudo_nan;
        logic pseudo_inf;
        logic int_pos;
        logic int_large;
        logic fault_token;
    } class_t;

    // IEEE-width subset flags, not exclusive
    typedef struct packed {
        logic sgl_normal;
        logic dbl_normal;
        logic ext_normal;
        logic sgl_denorm;
        logic dbl_denorm;
        logic pseudo_denorm_equiv;
    } subset_t;

    typedef enum logic [2:0] {
        FMT_REG,
        FMT_SGL,
        FMT_DBL,
        FMT_EXT,
        FMT_INT
    } wr_fmt_t;

endpackage

//--- design/fp_register_format_classifier.sv
// Floating-point register file with encoding classifier and constant entries
`timescale 1ns/1ps

module fp_register_format_classifier
    import fp_regfile_pkg::*;
#(
    parameter int NUM_REGS = 128,
    parameter int NUM_RD   = 2,
    parameter int ADDR_W   = 7
) (
    input  wire logic                             REF_CLK,
    input  wire logic                             RST,
    input  wire logic                             WR_EN,
    input  wire logic [ADDR_W-1:0]                WR_ADDR,
    input  wire fp_regfile_pkg::wr_fmt_t          WR_FMT,
    input  wire logic                             WR_ARITH,
    input  wire logic [81:0]                      WR_DATA,
    output      logic                             WR_REJECT,
    input  wire logic [NUM_RD-1:0]                RD_EN,
    input  wire logic [NUM_RD-1:0][ADDR_W-1:0]    RD_ADDR,
    output      logic [NUM_RD-1:0]                RD_VALID,
    output      fp_regfile_pkg::entry_t [NUM_RD-1:0]  RD_DATA,
    output      fp_regfile_pkg::class_t [NUM_RD-1:0]  RD_CLASS,
    output      fp_regfile_pkg::subset_t [NUM_RD-1:0] RD_SUBSET,
    output      logic [NUM_RD-1:0][17:0]          RD_TRUE_EXP,
    output      logic [NUM_RD-1:0]                RD_NEG
);
    import fp_regfile_pkg::*;

    if (NUM_REGS < 3 || NUM_REGS > (1 << ADDR_W) || NUM_RD < 1) begin : g_bad_param
        $error("fp register file parameters out of range");
    end

    // Classify one entry into its single encoding class
    function automatic class_t classify(input entry_t e);
        class_t c;
        c = '0;
        if (e.exp == EXP_SPECIAL) begin
            if (e.sig[INT_BIT]) begin
                if (e.sig[62:0] == 63'h0)
                    c.inf = 1'b1;
                else if (e.sig[QUIET_BIT])
                    c.qnan = 1'b1;
                else
                    c.snan = 1'b1;
            end else if (e.sig == 64'h0) begin
                c.pseudo_inf = 1'b1;
            end else begin
                c.pseudo_nan = 1'b1;
            end
        end else if (e == ENTRY_TOKEN) begin
            c.fault_token = 1'b1;
        end else if (!e.sign && e.exp == EXP_INT) begin
            // Canonical integer form wins over the generic normal/unnormal split
            if (e.sig[INT_BIT])
                c.int_large = 1'b1;
            else
                c.int_pos = 1'b1;
        end else if (e.exp == EXP_ZERO && e.sig == 64'h0) begin
            c.zero = 1'b1;
        end else if (e.exp != EXP_ZERO && e.sig[INT_BIT]) begin
            c.normal = 1'b1;
        end else begin
            c.unnormal = 1'b1;
        end
        return c;
    endfunction

    // Subset flags for IEEE-width values held in register format
    function automatic subset_t subsets(input entry_t e);
        subset_t s;
        logic    frac_nz;
        s = '0;
        frac_nz = (e.sig[62:0] != 63'h0);
        s.sgl_normal = e.sig[INT_BIT] && e.exp >= SGL_EXP_LO && e.exp <= SGL_EXP_HI
                       && e.sig[SGL_PAD-1:0] == 40'h0;
        s.dbl_normal = e.sig[INT_BIT] && e.exp >= DBL_EXP_LO && e.exp <= DBL_EXP_HI
                       && e.sig[DBL_PAD-1:0] == 11'h0;
        s.ext_normal = e.sig[INT_BIT] && e.exp >= EXT_EXP_LO && e.exp <= EXT_EXP_HI;
        s.sgl_denorm = !e.sig[INT_BIT] && e.exp == SGL_EXP_LO && frac_nz
                       && e.sig[SGL_PAD-1:0] == 40'h0;
        s.dbl_denorm = !e.sig[INT_BIT] && e.exp == DBL_EXP_LO && frac_nz
                       && e.sig[DBL_PAD-1:0] == 11'h0;
        s.pseudo_denorm_equiv = e.sig[INT_BIT] && e.exp == EXT_EXP_LO;
        return s;
    endfunction

    // Rebias a memory exponent into the register exponent range
    function automatic logic [16:0] rebias(input logic [16:0] mexp, input int bias);
        return 17'(int'(mexp) - bias + int'(EXP_REG_BIAS));
    endfunction

    // Convert the write word from its memory format into register format
    function automatic entry_t to_register(input wr_fmt_t f, input logic [81:0] d);
        entry_t           e;
        logic [SGL_EW-1:0] se;
        logic [DBL_EW-1:0] de;
        logic [EXT_EW-1:0] xe;
        e  = ENTRY_ZERO;
        se = d[SGL_TOTAL-2 -: SGL_EW];
        de = d[DBL_TOTAL-2 -: DBL_EW];
        xe = d[EXT_TOTAL-2 -: EXT_EW];
        case (f)
            FMT_REG: e = entry_t'(d);
            FMT_SGL: begin
                e.sign = d[SGL_TOTAL-1];
                e.sig  = {se != '0, d[SGL_FW-1:0], 40'h0};
                if (se == '1)
                    e.exp = EXP_SPECIAL;
                else if (se != '0)
                    e.exp = rebias(17'(se), SGL_BIAS);
                else if (d[SGL_FW-1:0] != '0)
                    e.exp = SGL_EXP_LO;
            end
            FMT_DBL: begin
                e.sign = d[DBL_TOTAL-1];
                e.sig  = {de != '0, d[DBL_FW-1:0], 11'h0};
                if (de == '1)
                    e.exp = EXP_SPECIAL;
                else if (de != '0)
                    e.exp = rebias(17'(de), DBL_BIAS);
                else if (d[DBL_FW-1:0] != '0)
                    e.exp = DBL_EXP_LO;
            end
            FMT_EXT: begin
                e.sign = d[EXT_TOTAL-1];
                e.sig  = d[EXT_FW-1:0];
                if (xe == '1)
                    e.exp = EXP_SPECIAL;
                else if (xe != '0)
                    e.exp = rebias(17'(xe), EXT_BIAS);
            end
            FMT_INT: e = '{sign: 1'b0, exp: EXP_INT, sig: d[SIG_W-1:0]};
            default: e = ENTRY_ZERO;
        endcase
        return e;
    endfunction

    // Storage and the converted write word
    entry_t      fpr_mem [NUM_REGS];
    entry_t      wr_entry;
    class_t      wr_class;
    logic        wr_pseudo;
    logic        wr_ok;

    // Converted write value and its legality
    assign wr_entry  = to_register(WR_FMT, WR_DATA);
    assign wr_class  = classify(wr_entry);
    // Only arithmetic results are policed; loads may carry any encoding
    assign wr_pseudo = wr_class.pseudo_nan || wr_class.pseudo_inf
                       || (wr_class.unnormal && wr_entry.sig == 64'h0)
                       || (wr_entry.exp == EXP_ZERO && wr_entry.sig[INT_BIT]);
    // Constant entries are never written; arithmetic pseudo results are dropped
    assign wr_ok = WR_EN && WR_ADDR >= ADDR_W'(2) && 32'(WR_ADDR) < NUM_REGS
                   && !(WR_ARITH && wr_pseudo);

    // Storage array, no reset: contents are undefined until written
    always_ff @(posedge REF_CLK) begin
        if (wr_ok) begin
            fpr_mem[WR_ADDR] <= wr_entry;
        end
    end

    // Rejection pulse, one cycle after the refused write
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            WR_REJECT <= 1'b0;
        end else begin
            WR_REJECT <= WR_EN && !wr_ok;
        end
    end

    for (genvar p = 0; p < NUM_RD; p++) begin : g_rd
        // Registered read; entries 0 and 1 are hard constants
        always_ff @(posedge REF_CLK or posedge RST) begin
            if (RST) begin
                RD_DATA[p]  <= entry_t'(ENTRY_RESET);
                RD_VALID[p] <= 1'b0;
            end else begin
                RD_VALID[p] <= RD_EN[p];
                if (RD_EN[p]) begin
                    if (RD_ADDR[p] == ADDR_W'(0))
                        RD_DATA[p] <= ENTRY_ZERO;
                    else if (RD_ADDR[p] == ADDR_W'(1))
                        RD_DATA[p] <= ENTRY_ONE;
                    else if (32'(RD_ADDR[p]) < NUM_REGS)
                        RD_DATA[p] <= fpr_mem[RD_ADDR[p]];
                    else
                        RD_DATA[p] <= ENTRY_ZERO; // Out of range reads as zero
                end
            end
        end

        // Class, subsets and value fields follow the held entry directly
        assign RD_CLASS[p]  = classify(RD_DATA[p]);
        assign RD_SUBSET[p] = subsets(RD_DATA[p]);
        assign RD_NEG[p]    = RD_DATA[p].sign;
        assign RD_TRUE_EXP[p] = (RD_DATA[p].exp == EXP_ZERO) ? 18'(DENORM_EXP)
                              : 18'({1'b0, RD_DATA[p].exp} - {1'b0, EXP_REG_BIAS});
    end

    // Assertions share the one clock and stay quiet during reset
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    const_zero_a: assert property (RD_EN[0] && RD_ADDR[0] == ADDR_W'(0)
        |=> RD_DATA[0] == ENTRY_ZERO && RD_CLASS[0].zero && RD_VALID[0])
        else $error("entry 0 did not read as positive zero");
    const_one_a: assert property (RD_EN[0] && RD_ADDR[0] == ADDR_W'(1)
        |=> RD_DATA[0] == ENTRY_ONE && RD_CLASS[0].normal && RD_TRUE_EXP[0] == 18'h0)
        else $error("entry 1 did not read as positive one");
    class_onehot_a: assert property ($onehot(RD_CLASS[0]))
        else $error("class vector is not one-hot");
    inf_class_a: assert property (RD_DATA[0].exp == EXP_SPECIAL
        && RD_DATA[0].sig == 64'h8000000000000000 |-> RD_CLASS[0].inf)
        else $error("infinity encoding not classified as infinity");
    qnan_class_a: assert property (RD_DATA[0].exp == EXP_SPECIAL
        && RD_DATA[0].sig[63:62] == 2'b11 |-> RD_CLASS[0].qnan && !RD_CLASS[0].snan)
        else $error("quiet NaN misclassified");
    token_class_a: assert property (RD_DATA[0] == ENTRY_TOKEN
        |-> RD_CLASS[0].fault_token)
        else $error("deferred-fault token not recognised");
    const_write_a: assert property (WR_EN && WR_ADDR < ADDR_W'(2) |=> WR_REJECT)
        else $error("write to a constant entry was not refused");
    pseudo_write_a: assert property (WR_EN && WR_ARITH && WR_FMT == FMT_REG
        && WR_DATA[80:64] == EXP_SPECIAL && !WR_DATA[63] |=> WR_REJECT)
        else $error("pseudo encoding accepted from arithmetic write");
    true_exp_a: assert property (RD_VALID[0] && RD_DATA[0].exp != EXP_ZERO
        |-> RD_TRUE_EXP[0] == 18'({1'b0, RD_DATA[0].exp} - 18'h0FFFF))
        else $error("true exponent wrong for nonzero exponent");
    denorm_exp_a: assert property (RD_DATA[0].exp == EXP_ZERO
        |-> RD_TRUE_EXP[0] == 18'h3C002)
        else $error("true exponent wrong for zero exponent");

    // Remaining classes, each on the port where the bench reads it
    snan_class_a: assert property (RD_DATA[1].exp == EXP_SPECIAL
        && RD_DATA[1].sig[63:62] == 2'b10 && RD_DATA[1].sig[61:0] != 62'h0
        |-> RD_CLASS[1].snan)
        else $error("signaling NaN misclassified");
    zero_class_a: assert property (RD_DATA[1].exp == EXP_ZERO
        && RD_DATA[1].sig == 64'h0 |-> RD_CLASS[1].zero)
        else $error("zero encoding not classified as zero");
    unnormal_class_a: assert property (RD_DATA[0].exp == EXP_ZERO
        && RD_DATA[0].sig != 64'h0 |-> RD_CLASS[0].unnormal)
        else $error("zero exponent with nonzero significand not unnormal");
    pseudo_zero_a: assert property (RD_DATA[1].sign && RD_DATA[1].sig == 64'h0
        && RD_DATA[1].exp != EXP_ZERO && RD_DATA[1].exp != EXP_SPECIAL
        |-> RD_CLASS[1].unnormal)
        else $error("negative pseudo-zero not classified as unnormal");
    normal_class_a: assert property (RD_DATA[0].sig[INT_BIT]
        && RD_DATA[0].exp != EXP_ZERO && RD_DATA[0].exp != EXP_SPECIAL
        && !(!RD_DATA[0].sign && RD_DATA[0].exp == EXP_INT) |-> RD_CLASS[0].normal)
        else $error("normalized encoding not classified as normal");
    int_large_a: assert property (!RD_DATA[0].sign && RD_DATA[0].exp == EXP_INT
        && RD_DATA[0].sig[INT_BIT] |-> RD_CLASS[0].int_large)
        else $error("large integer form not recognised");
    int_pos_a: assert property (!RD_DATA[1].sign && RD_DATA[1].exp == EXP_INT
        && !RD_DATA[1].sig[INT_BIT] |-> RD_CLASS[1].int_pos)
        else $error("positive integer form not recognised");
    class_onehot1_a: assert property ($onehot(RD_CLASS[1]))
        else $error("class vector on port 1 is not one-hot");

    // Read handshake on both ports and constant entry on the second port
    valid_pulse_a: assert property (RD_EN[0] |=> RD_VALID[0])
        else $error("read on port 0 gave no valid pulse");
    valid_idle_a: assert property (!RD_EN[1] |=> !RD_VALID[1])
        else $error("port 1 valid without a read");
    const_one1_a: assert property (RD_EN[1] && RD_ADDR[1] == ADDR_W'(1)
        |=> RD_DATA[1] == ENTRY_ONE && RD_VALID[1])
        else $error("entry 1 did not read as positive one on port 1");

    // Write acceptance and refusal
    pseudo_denorm_write_a: assert property (WR_EN && WR_ARITH && WR_FMT == FMT_REG
        && WR_DATA[80:64] == EXP_ZERO && WR_DATA[63] |=> WR_REJECT)
        else $error("pseudo-denormal accepted from arithmetic write");
    plain_write_a: assert property (WR_EN && !WR_ARITH && WR_ADDR >= ADDR_W'(2)
        && 32'(WR_ADDR) < NUM_REGS |=> !WR_REJECT)
        else $error("write to a writable entry was refused");

    zero_read_c: cover property (RD_VALID[0] && RD_CLASS[0].zero);
    snan_read_c: cover property (RD_VALID[0] && RD_CLASS[0].snan);
    sgl_store_c: cover property (WR_EN && WR_FMT == FMT_SGL ##1 !WR_REJECT);
    reject_c:    cover property (WR_REJECT);
    int_read_c:  cover property (RD_VALID[0] && RD_CLASS[0].int_large);

endmodule

//--- test/fp_exec_partner.sv
// Execution-unit and load/store stand-in driving the register file ports
`timescale 1ns/1ps
module fp_exec_partner
    import fp_regfile_pkg::*;
(
    input  wire logic                 clk,
    output      logic                 wr_en,
    output      logic [6:0]           wr_addr,
    output      fp_regfile_pkg::wr_fmt_t wr_fmt,
    output      logic                 wr_arith,
    output      logic [81:0]          wr_data,
    input  wire logic                 wr_reject,
    output      logic [1:0]           rd_en,
    output      logic [1:0][6:0]      rd_addr
);
    import fp_regfile_pkg::*;

    // Idle values at time zero
    initial begin
        wr_en = 1'b0;
        wr_addr = 7'h00;
        wr_fmt = FMT_REG;
        wr_arith = 1'b0;
        wr_data = 82'h0;
        rd_en = 2'h0;
        rd_addr = '0;
    end

    // One write; refusal may show on either of the two following edges
    task automatic write_entry(input logic [6:0] a, input wr_fmt_t f, input logic ar,
                               input logic [81:0] d, output logic rej);
        @(posedge clk);
        #1;
        wr_en = 1'b1;
        wr_addr = a;
        wr_fmt = f;
        wr_arith = ar;
        wr_data = d;
        @(posedge clk);
        #1;
        wr_en = 1'b0;
        wr_data = ~d; // Released data must not look valid
        rej = wr_reject;
        @(posedge clk);
        #1;
        rej = rej | wr_reject;
    endtask

    // One read; outputs are settled when this returns
    task automatic read_entry(input int p, input logic [6:0] a);
        @(posedge clk);
        #1;
        rd_en[p] = 1'b1;
        rd_addr[p] = a;
        @(posedge clk);
        #1;
        rd_en[p] = 1'b0;
        rd_addr[p] = ~a;
    endtask
endmodule

//--- test/fp_register_format_classifier_tb.sv
// Self-checking bench for the register file classifier
`timescale 1ns/1ps
module fp_register_format_classifier_tb;
    import fp_regfile_pkg::*;

    logic                ref_clk = 1'b0;
    logic                rst = 1'b1;
    logic                wr_en, wr_arith, wr_reject, rej;
    logic [6:0]          wr_addr;
    wr_fmt_t             wr_fmt;
    logic [81:0]         wr_data;
    logic [1:0]          rd_en, rd_valid, rd_neg;
    logic [1:0][6:0]     rd_addr;
    entry_t  [1:0]       rd_data;
    class_t  [1:0]       rd_class;
    subset_t [1:0]       rd_subset;
    logic [1:0][17:0]    rd_true_exp;
    int                  err_count = 0;
    int                  checked = 0;

    // 40 MHz clock
    always #12.5 ref_clk = ~ref_clk;

    fp_register_format_classifier uut (.REF_CLK(ref_clk), .RST(rst), .WR_EN(wr_en),
        .WR_ADDR(wr_addr), .WR_FMT(wr_fmt), .WR_ARITH(wr_arith), .WR_DATA(wr_data),
        .WR_REJECT(wr_reject), .RD_EN(rd_en), .RD_ADDR(rd_addr), .RD_VALID(rd_valid),
        .RD_DATA(rd_data), .RD_CLASS(rd_class), .RD_SUBSET(rd_subset),
        .RD_TRUE_EXP(rd_true_exp), .RD_NEG(rd_neg));

    fp_exec_partner px (.clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_fmt(wr_fmt),
        .wr_arith(wr_arith), .wr_data(wr_data), .wr_reject(wr_reject), .rd_en(rd_en),
        .rd_addr(rd_addr));

    // Shared compare, zero-extends narrow values
    task automatic chk(input logic [81:0] got, input logic [81:0] exp);
        checked++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask

    task report_and_stop;
        $display("errors=%0d checks=%0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Constant entries and a refused write to entry 1
    task t_constants;
        px.read_entry(0, 7'h00);
        chk(rd_valid[0], 1'b1);
        chk(rd_data[0], ENTRY_ZERO);
        @(posedge ref_clk);
        #1;
        chk(rd_valid[0], 1'b0);
        px.read_entry(1, 7'h01);
        chk(rd_data[1], ENTRY_ONE);
        chk(rd_true_exp[1], 18'h0);
        px.write_entry(7'h01, FMT_REG, 1'b0, 82'h0, rej);
        chk(rej, 1'b1);
        px.read_entry(0, 7'h01);
        chk(rd_data[0], ENTRY_ONE);
    endtask

    // Raw encodings against their one-hot class
    task t_classes;
        logic [81:0] e [14] = '{
            {1'b0, 17'h1FFFF, 64'h8000000000000000}, {1'b1, 17'h1FFFF, 64'h8000000000000000},
            {1'b0, 17'h1FFFF, 64'hC000000000000000}, {1'b1, 17'h1FFFF, 64'h8000000000000001},
            {1'b0, 17'h1FFFF, 64'h0}, {1'b1, 17'h00000, 64'h0},
            {1'b0, 17'h0FFFE, 64'h8000000000000000}, {1'b1, 17'h0FFFF, 64'h4000000000000000},
            {1'b0, 17'h1FFFE, 64'h0}, {1'b1, 17'h1FFFE, 64'h0},
            {1'b0, 17'h00000, 64'h0000000000000001}, {1'b0, 17'h1003E, 64'h7FFFFFFFFFFFFFFF},
            {1'b0, 17'h1003E, 64'h8000000000000000}, {1'b1, 17'h1FFFE, 64'h8000000000000000}};
        logic [10:0] c [14] = '{11'h080, 11'h080, 11'h040, 11'h020, 11'h008, 11'h400,
            11'h200, 11'h100, 11'h001, 11'h100, 11'h100, 11'h004, 11'h002, 11'h200};
        logic [17:0] texp;
        for (int i = 0; i < 14; i++) begin
            px.write_entry(7'(2 + i), FMT_REG, 1'b0, e[i], rej);
            chk(rej, 1'b0);
            px.read_entry(i % 2, 7'(2 + i));
            chk(rd_valid[i % 2], 1'b1);
            texp = (e[i][80:64] == 17'h0) ? 18'h3C002 : 18'({1'b0, e[i][80:64]} - 18'h0FFFF);
            chk(rd_data[i % 2], e[i]);
            chk(rd_class[i % 2], c[i]);
            chk(rd_neg[i % 2], e[i][81]);
            chk(rd_true_exp[i % 2], texp);
        end
    endtask

    // Memory-format conversion and subset flags
    task t_formats;
        wr_fmt_t     f [6] = '{FMT_SGL, FMT_DBL, FMT_EXT, FMT_SGL, FMT_INT, FMT_REG};
        logic [81:0] d [6] = '{82'h3F800000, 82'h3FF0000000000000,
            82'h3FFF8000000000000000, 82'h1, 82'h5, {1'b0, 17'h0C001, 64'h8000000000000000}};
        logic [81:0] e [6] = '{ENTRY_ONE, ENTRY_ONE, ENTRY_ONE,
            {1'b0, 17'h0FF81, 64'h0000010000000000}, {1'b0, 17'h1003E, 64'h5},
            {1'b0, 17'h0C001, 64'h8000000000000000}};
        logic [5:0]  s [6] = '{6'h38, 6'h38, 6'h38, 6'h04, 6'h00, 6'h09};
        for (int i = 0; i < 6; i++) begin
            px.write_entry(7'(40 + i), f[i], 1'b0, d[i], rej);
            chk(rej, 1'b0);
            px.read_entry(1, 7'(40 + i));
            chk(rd_data[1], e[i]);
            chk(rd_subset[1], s[i]);
        end
    endtask

    // Arithmetic results with pseudo encodings are refused
    task t_arith;
        px.write_entry(7'h50, FMT_REG, 1'b1, ENTRY_ONE, rej);
        chk(rej, 1'b0);
        px.write_entry(7'h50, FMT_REG, 1'b1, {1'b0, 17'h1FFFF, 64'h0}, rej);
        chk(rej, 1'b1);
        px.write_entry(7'h50, FMT_REG, 1'b1, {1'b0, 17'h00000, 64'h8000000000000000}, rej);
        chk(rej, 1'b1);
        px.read_entry(0, 7'h50);
        chk(rd_data[0], ENTRY_ONE);
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        t_constants();
        t_classes();
        t_formats();
        t_arith();
        report_and_stop();
    end

    // Watchdog, far beyond the roughly 133 cycles the tests need
    initial begin
        #(25 * 5000);
        err_count++;
        report_and_stop();
    end
endmodule
